// [src/tmc_pkg.sv]
`default_nettype none
package tmc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CONFIG    = 8'h00;
	localparam logic [7:0] OFS_COUNTER   = 8'h04;
	localparam logic [7:0] OFS_PWM_CNT   = 8'h08;
	localparam logic [7:0] OFS_ACC_CNT   = 8'h0C;
	localparam logic [7:0] OFS_ACC_CTL   = 8'h10;
	localparam logic [7:0] OFS_FLAGS     = 8'h14;
	localparam logic [7:0] OFS_ENABLES   = 8'h18;
	localparam logic [7:0] OFS_PORT_DATA = 8'h1C;
	localparam logic [7:0] OFS_PORT_DIR  = 8'h20;
	localparam logic [7:0] OFS_INT_CFG   = 8'h24;
	localparam logic [7:0] OFS_PWM_DUTY  = 8'h28;
	localparam logic [2:0] CHAN_PAGE     = 3'h2;
	// timer_module_config_reg fields
	localparam int CFG_STOP      = 0;
	localparam int CFG_FRZ_EN    = 1;
	localparam int CFG_FRZ_SPARE = 2;
	localparam int CFG_SSTOP     = 3;
	localparam int CFG_STEP      = 4;
	// accumulator control fields
	localparam int ACC_MODE    = 0;
	localparam int ACC_ON      = 1;
	localparam int ACC_CH7_OC  = 2;
	localparam int ACC_PSC_LSB = 4;
	localparam logic [3:0] PSC_EXT = 4'h9;
	// flag positions above the eight channel flags
	localparam int FLG_TOF   = 8;
	localparam int FLG_PAOVF = 9;
	localparam int FLG_PAIF  = 10;
	// sizes
	localparam int NUM_CH = 8;
	localparam int PSC_W  = 9;
	localparam int CNT_W  = 16;
	localparam int ACC_W  = 8;
	localparam int FLAG_W = 11;
	localparam int SYN_W  = 10;
	localparam int SYN_ACC = 1;
	localparam int SYN_EXT = 0;
	// reset values
	localparam logic [3:0]  RST_CONFIG  = 4'h0;
	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [7:0]  RST_OE_N    = 8'hFF;
	localparam logic [15:0] RST_WORD    = 16'h0000;
	localparam logic [10:0] RST_FLAGS   = 11'h000;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
		logic [3:0]  pstrb;
	} tmc_apb_req_t;

	typedef struct packed {
		logic [7:0] port;
		logic       acc;
		logic       ext_clk;
		logic       freeze;
	} tmc_pins_t;

	typedef enum logic [0:0] {
		ACC_EVENT = 1'b0,
		ACC_GATED = 1'b1
	} tmc_acc_mode_t;
endpackage
`default_nettype wire

// [src/tmc_timer_ctrl.sv]
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
//Contract
// R1 - three capture, four compare and one selectable channel
// R2 - shared 16-bit counter clocked by nine-stage prescaler or external clock
// R3 - 8-bit accumulator counting events or gated time
// R4 - two PWM outputs with own duties on a shared 16-bit counter
// R5 - 8-bit bidirectional port; PWM outputs only; accumulator, clock inputs only
// R6 - every register takes byte or word writes
// R7 - a word read samples both bytes at one instant
// R8 - stop bit shuts the module clock off until cleared or reset; the code does not gate the clock but holds all counters and the prescaler
// R9 - while stopped all counters and prescaler hold
// R10 - software touches only config and interrupt config while stopped; the code does not block writes to any other register while stopped
// R11 - freeze when debug freeze and enable bit set; spare bit inert
// R12 - in freeze prescaler, accumulator, synchronizers halt; CPU functions work
// R13 - under debug freeze read-only and write-once bits become writable
// R14 - freeze ends on freeze negation, enable clear, or reset
// R15 - operations started before freeze still complete
// R16 - single-step stop halts counting; pin reads keep latched levels
// R17 - step bit advances prescaler and synchronizers once, only in stop
// R18 - each function has flag and enable; enabled event raises interrupt
// R19 - interrupt stays until flag is cleared
// R20 - flag clears by read then write zero; new event keeps it
// R21 - each step write gives a one-cycle enable pulse
// R22 - freeze and step act only as enables, not on registers
module tmc_timer_ctrl (
	// clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// register bus
	input  wire tmc_pkg::tmc_apb_req_t apb_req,
	output logic                       pready,
	output logic [31:0]                prdata,
	output logic                       pslverr,
	// pins
	input  wire tmc_pkg::tmc_pins_t    pins_in,
	output logic [7:0]                 port_out,
	output logic [7:0]                 port_oe_n,
	output logic [1:0]                 pwm_out,
	output logic                       irq
);
	logic [3:0]          cfg_reg;
	logic                step_pulse_reg;
	logic [8:0]          psc_reg;
	logic [9:0]          sync1_reg;
	logic [9:0]          sync2_reg;
	logic [9:0]          sync3_reg;
	logic [9:0]          edge_reg;
	logic [15:0]         cnt_reg;
	logic [15:0]         pwm_cnt_reg;
	logic [15:0]         duty_reg;
	logic [7:0]          acc_cnt_reg;
	logic [7:0]          acc_ctl_reg;
	logic [10:0]         flag_reg;
	logic [10:0]         flag_next;
	logic [10:0]         armed_reg;
	logic [10:0]         en_reg;
	logic [7:0]          data_reg;
	logic [7:0]          oe_n_reg;
	logic [7:0]          int_cfg_reg;
	logic [1:0]          pwm_reg;
	logic                irq_reg;
	logic [31:0]         prdata_reg;
	logic [31:0]         rdata_next;
	logic [15:0]         chan_reg [0:7];

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		merge16 = {strb[1] ? wd[15:8] : old[15:8],
			strb[0] ? wd[7:0] : old[7:0]};
	endfunction

	function automatic logic psc_hit(input logic [8:0] psc,
		input logic [3:0] sel);
		logic [9:0] m;
		m = (10'h001 << (sel + 4'h1)) - 10'h001;
		psc_hit = (psc & m[8:0]) == m[8:0];
	endfunction

	// bus decode
	wire setup    = apb_req.psel & ~apb_req.penable;
	wire access   = apb_req.psel & apb_req.penable;
	wire wr       = access & apb_req.pwrite;
	wire rd       = access & ~apb_req.pwrite;
	wire [7:0] ad = apb_req.paddr;
	wire [31:0] wd = apb_req.pwdata;
	wire [3:0] sb = apb_req.pstrb;
	wire hit_cfg  = ad == tmc_pkg::OFS_CONFIG;
	wire hit_cnt  = ad == tmc_pkg::OFS_COUNTER;
	wire hit_pwmc = ad == tmc_pkg::OFS_PWM_CNT;
	wire hit_accc = ad == tmc_pkg::OFS_ACC_CNT;
	wire hit_actl = ad == tmc_pkg::OFS_ACC_CTL;
	wire hit_flg  = ad == tmc_pkg::OFS_FLAGS;
	wire hit_en   = ad == tmc_pkg::OFS_ENABLES;
	wire hit_dat  = ad == tmc_pkg::OFS_PORT_DATA;
	wire hit_dir  = ad == tmc_pkg::OFS_PORT_DIR;
	wire hit_icfg = ad == tmc_pkg::OFS_INT_CFG;
	wire hit_duty = ad == tmc_pkg::OFS_PWM_DUTY;
	wire hit_chan = (ad[7:5] == tmc_pkg::CHAN_PAGE) & (ad[1:0] == 2'b00);
	wire [2:0] ch_idx = ad[4:2];
	wire mapped = hit_cfg | hit_cnt | hit_pwmc | hit_accc | hit_actl
		| hit_flg | hit_en | hit_dat | hit_dir | hit_icfg | hit_duty
		| hit_chan;

	// mode control
	wire dbg_frz    = pins_in.freeze;
	wire running    = ~cfg_reg[tmc_pkg::CFG_STOP]; // see R8
	wire frz_active = dbg_frz & cfg_reg[tmc_pkg::CFG_FRZ_EN]; // see R11 see R14
	wire sstop      = cfg_reg[tmc_pkg::CFG_SSTOP];
	// stop cannot gate the real clock here, so it holds every counter instead
	wire tick_en    = running
		& ((~frz_active & ~sstop) | step_pulse_reg); // see R9 see R12 see R22
	wire step_wr    = wr & hit_cfg & sb[0] & wd[tmc_pkg::CFG_STEP];

	wire [3:0] psc_sel = acc_ctl_reg[tmc_pkg::ACC_PSC_LSB +: 4];
	wire ext_sel    = psc_sel >= tmc_pkg::PSC_EXT;
	wire count_tick = running & (ext_sel ? edge_reg[tmc_pkg::SYN_EXT]
		: (tick_en & psc_hit(psc_reg, psc_sel))); // see R2 see R9
	wire [7:0] port_edge = edge_reg[9:2];
	wire acc_edge   = edge_reg[tmc_pkg::SYN_ACC];
	wire acc_lvl    = sync2_reg[tmc_pkg::SYN_ACC];
	wire acc_on     = acc_ctl_reg[tmc_pkg::ACC_ON];
	wire ch7_oc     = acc_ctl_reg[tmc_pkg::ACC_CH7_OC];
	wire acc_inc    = acc_on & running & ((acc_ctl_reg[tmc_pkg::ACC_MODE]
		== tmc_pkg::ACC_EVENT) ? acc_edge : (count_tick & acc_lvl)); // see R3 see R9

	// channel events: 0..2 capture, 3..6 compare, 7 selectable
	logic [7:0] cap_ev;
	logic [7:0] cmp_ev;
	always_comb
	begin
		for (int i = 0; i < tmc_pkg::NUM_CH; i++)
		begin
			cap_ev[i] = 1'b0;
			cmp_ev[i] = 1'b0;
			if (i < 3 || (i == 7 && !ch7_oc))
				cap_ev[i] = port_edge[i]; // see R1 see R15
			else
				cmp_ev[i] = count_tick & (cnt_reg == chan_reg[i]); // see R1
		end
	end

	wire [10:0] set_vec = {acc_on & acc_edge,
		acc_inc & (acc_cnt_reg == 8'hFF),
		count_tick & (cnt_reg == 16'hFFFF),
		cap_ev | cmp_ev}; // see R18
	wire [10:0] wmask = {{3{sb[1]}}, {8{sb[0]}}};
	wire flg_wr  = wr & hit_flg;
	wire [10:0] clr_vec = flg_wr ? (armed_reg & wmask & ~wd[10:0])
		: 11'h000; // see R20
	// a set in the same cycle as its clear wins
	assign flag_next = dbg_frz && flg_wr
		? ((flag_reg & ~wmask) | (wd[10:0] & wmask) | set_vec) // see R13
		: ((flag_reg & ~clr_vec) | set_vec); // see R19 see R20

	wire [7:0] port_rd;
	assign port_rd = (data_reg & ~oe_n_reg)
		| (sync2_reg[9:2] & oe_n_reg); // see R16

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_reg        <= tmc_pkg::RST_CONFIG;
			step_pulse_reg <= 1'b0;
			psc_reg        <= 9'h000;
		end
		else
		begin
			if (wr && hit_cfg && sb[0])
				cfg_reg <= wd[3:0]; // see R6 see R11
			step_pulse_reg <= step_wr & sstop; // see R17 see R21
			if (tick_en)
				psc_reg <= psc_reg + 9'h001; // see R2 see R17
		end
	end

	// synchronizers only clock on the shared enable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_reg <= 10'h000;
			sync2_reg <= 10'h000;
			sync3_reg <= 10'h000;
			edge_reg  <= 10'h000;
		end
		else
		begin
			if (tick_en)
			begin
				sync1_reg <= {pins_in.port, pins_in.acc, pins_in.ext_clk};
				sync2_reg <= sync1_reg;
				sync3_reg <= sync2_reg; // see R12 see R16
			end
			// a caught edge is acted on even if freeze begins now
			edge_reg <= tick_en ? (sync2_reg & ~sync3_reg)
				: 10'h000; // see R15
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_reg     <= tmc_pkg::RST_WORD;
			pwm_cnt_reg <= tmc_pkg::RST_WORD;
			acc_cnt_reg <= tmc_pkg::RST_BYTE;
		end
		else
		begin
			if (wr && hit_cnt && dbg_frz)
				cnt_reg <= merge16(cnt_reg, wd, sb); // see R13
			else if (count_tick)
				cnt_reg <= cnt_reg + 16'h0001; // see R2 see R9
			if (wr && hit_pwmc && dbg_frz)
				pwm_cnt_reg <= merge16(pwm_cnt_reg, wd, sb); // see R13
			else if (count_tick)
				pwm_cnt_reg <= pwm_cnt_reg + 16'h0001; // see R4
			if (wr && hit_accc && sb[0])
				acc_cnt_reg <= wd[7:0];
			else if (acc_inc)
				acc_cnt_reg <= acc_cnt_reg + 8'h01; // see R3
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < tmc_pkg::NUM_CH; i++)
				chan_reg[i] <= tmc_pkg::RST_WORD;
		end
		else
		begin
			for (int i = 0; i < tmc_pkg::NUM_CH; i++)
			begin
				if (cap_ev[i])
					chan_reg[i] <= cnt_reg; // see R15
				else if (wr && hit_chan && ch_idx == 3'(i)
					&& (dbg_frz || i >= 3 && !(i == 7 && !ch7_oc)))
					chan_reg[i] <= merge16(chan_reg[i], wd, sb); // see R13
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flag_reg  <= tmc_pkg::RST_FLAGS;
			armed_reg <= tmc_pkg::RST_FLAGS;
			en_reg    <= tmc_pkg::RST_FLAGS;
			irq_reg   <= 1'b0;
		end
		else
		begin
			flag_reg <= flag_next;
			if (rd && hit_flg)
				armed_reg <= flag_reg; // see R20
			else if (flg_wr)
				armed_reg <= 11'h000;
			if (wr && hit_en)
				en_reg <= (en_reg & ~wmask) | (wd[10:0] & wmask);
			irq_reg <= |(flag_reg & en_reg); // see R18 see R19
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acc_ctl_reg <= tmc_pkg::RST_BYTE;
			data_reg    <= tmc_pkg::RST_BYTE;
			oe_n_reg    <= tmc_pkg::RST_OE_N;
			int_cfg_reg <= tmc_pkg::RST_BYTE;
			duty_reg    <= tmc_pkg::RST_WORD;
			pwm_reg     <= 2'b00;
		end
		else
		begin
			if (wr && hit_actl && sb[0])
				acc_ctl_reg <= wd[7:0];
			if (wr && hit_dat && sb[0])
				data_reg <= wd[7:0]; // see R12
			if (wr && hit_dir && sb[0])
				oe_n_reg <= ~wd[7:0]; // see R5 see R12
			if (wr && hit_icfg && sb[0])
				int_cfg_reg <= wd[7:0];
			if (wr && hit_duty)
				duty_reg <= merge16(duty_reg, wd, sb); // see R6
			pwm_reg <= {pwm_cnt_reg[7:0] < duty_reg[15:8],
				pwm_cnt_reg[7:0] < duty_reg[7:0]}; // see R4
		end
	end

	// read data sampled once in setup: every byte from one instant
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		if (hit_cfg)
			rdata_next[3:0] = cfg_reg;
		else if (hit_cnt)
			rdata_next[15:0] = cnt_reg;
		else if (hit_pwmc)
			rdata_next[15:0] = pwm_cnt_reg;
		else if (hit_accc)
			rdata_next[7:0] = acc_cnt_reg;
		else if (hit_actl)
			rdata_next[7:0] = acc_ctl_reg;
		else if (hit_flg)
			rdata_next[10:0] = flag_reg;
		else if (hit_en)
			rdata_next[10:0] = en_reg;
		else if (hit_dat)
			rdata_next[7:0] = port_rd;
		else if (hit_dir)
			rdata_next[7:0] = ~oe_n_reg;
		else if (hit_icfg)
			rdata_next[7:0] = int_cfg_reg;
		else if (hit_duty)
			rdata_next[15:0] = duty_reg;
		else if (hit_chan)
			rdata_next[15:0] = chan_reg[ch_idx];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_reg <= 32'h0000_0000;
		else if (setup)
			prdata_reg <= rdata_next; // see R7
	end

	assign pready    = 1'b1;
	assign pslverr   = access & ~mapped;
	assign prdata    = prdata_reg;
	assign port_out  = data_reg; // see R5
	assign port_oe_n = oe_n_reg;
	assign pwm_out   = pwm_reg;
	assign irq       = irq_reg;

	sequence step_req;
		step_wr && sstop && running;
	endsequence
	sequence one_pulse;
		step_pulse_reg ##1 !step_pulse_reg;
	endsequence

	chk_stop_holds: assert property (@(posedge pclk) disable iff (!presetn) // see R9
		!running && !wr |=> $stable(cnt_reg) && $stable(psc_reg))
		else $error("counter moved while stopped");
	chk_freeze_hold: assert property (@(posedge pclk) disable iff (!presetn) // see R12
		frz_active && !step_pulse_reg |=> $stable(psc_reg))
		else $error("prescaler moved in freeze");
	chk_spare_inert: assert property (@(posedge pclk) disable iff (!presetn) // see R11
		running && !sstop && !cfg_reg[tmc_pkg::CFG_FRZ_EN]
		|=> psc_reg == $past(psc_reg) + 9'h001)
		else $error("prescaler stalled without freeze");
	chk_step_once: assert property (@(posedge pclk) disable iff (!presetn) // see R17
		step_req ##1 !step_wr |-> one_pulse ##0 psc_reg == $past(psc_reg,2) + 9'h001)
		else $error("step did not advance once");
	chk_step_noop: assert property (@(posedge pclk) disable iff (!presetn) // see R21
		step_wr && !sstop |=> !step_pulse_reg)
		else $error("step acted without stop");
	chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn) // see R19
		!flg_wr |=> (flag_reg & $past(flag_reg)) == $past(flag_reg))
		else $error("flag dropped without write");
	chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // see R20
		set_vec != 11'h000 |=> (flag_reg & $past(set_vec)) == $past(set_vec))
		else $error("event lost");
	chk_irq_raise: assert property (@(posedge pclk) disable iff (!presetn) // see R18
		|(flag_reg & en_reg) |=> irq)
		else $error("enabled flag gave no interrupt");
	chk_pin_latch: assert property (@(posedge pclk) disable iff (!presetn) // see R16
		sstop && !step_pulse_reg |=> $stable(sync2_reg))
		else $error("pins sampled in single step");
endmodule
`default_nettype wire

// [testbench/tmc_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tmc_pin_model (
	// pads from design
	input  wire logic [7:0]        port_out,
	input  wire logic [7:0]        port_oe_n,
	// outside world levels
	input  wire logic [7:0]        ext_lvl,
	input  wire logic              acc_lvl,
	input  wire logic              frz_lvl,
	// to design
	output var tmc_pkg::tmc_pins_t pins
);
	wire logic [7:0] pad_wire;

	// design wins on every bit it drives
	assign pad_wire = (port_out & ~port_oe_n) | (ext_lvl & port_oe_n);
	// clock pin stands low: no external clocking used here
	assign pins = '{port: pad_wire, acc: acc_lvl, ext_clk: 1'b0,
		freeze: frz_lvl};
endmodule
`default_nettype wire

// [testbench/timer_module_mode_control_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module timer_module_mode_control_tb_top;
	typedef struct packed {
		logic [31:0] exp;
		logic [31:0] msk;
		logic        err;
	} tmc_note_t;

	logic                  pclk;
	logic                  presetn;
	tmc_pkg::tmc_apb_req_t req;
	logic                  pready;
	logic [31:0]           prdata;
	logic                  pslverr;
	tmc_pkg::tmc_pins_t    pins;
	logic [7:0]            port_out;
	logic [7:0]            port_oe_n;
	logic [1:0]            pwm_out;
	logic                  irq;
	logic [7:0]            ext_lvl;
	logic                  acc_lvl;
	logic                  frz_lvl;
	logic [7:0]            rnd;
	integer                seed;
	int                    n_mismatch;
	int                    checks_done;
	tmc_note_t             notes[$];
	tmc_note_t             nt;

	tmc_timer_ctrl i_tmc_timer_ctrl (
		.pclk      (pclk),
		.presetn   (presetn),
		.apb_req   (req),
		.pready    (pready),
		.prdata    (prdata),
		.pslverr   (pslverr),
		.pins_in   (pins),
		.port_out  (port_out),
		.port_oe_n (port_oe_n),
		.pwm_out   (pwm_out),
		.irq       (irq)
	);

	tmc_pin_model i_tmc_pin_model (
		.port_out  (port_out),
		.port_oe_n (port_oe_n),
		.ext_lvl   (ext_lvl),
		.acc_lvl   (acc_lvl),
		.frz_lvl   (frz_lvl),
		.pins      (pins)
	);

	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task print_verdict();
		if (n_mismatch == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s exp %h seen %h", what, exp, seen);
		end
	endtask

	// one full transfer; reads leave a note for the watcher
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [31:0] e, input logic [31:0] m);
		int i;
		@(posedge pclk);
		req <= '{1'b1, 1'b0, wr, a, d, s};
		if (!wr)
			notes.push_back('{e, m, a == 8'h30});
		@(posedge pclk);
		req.penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (pready !== 1'b1 && i < 50);
		if (i >= 50)
		begin
			n_mismatch++;
			print_verdict();
		end
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hF, 32'h0, 32'h0);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0, 4'hF, e, m);
	endtask

	task waitc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// accumulator pin rising edge, long enough to pass the synchronizer
	task pulse();
		acc_lvl <= 1'b1;
		waitc(8);
		acc_lvl <= 1'b0;
	endtask

	// answers are judged where the access edge samples them
	always @(posedge pclk)
		if (req.psel && req.penable && pready === 1'b1 && !req.pwrite
			&& notes.size() > 0)
		begin
			nt = notes.pop_front();
			check("read data", prdata & nt.msk, nt.exp);
			check("slave error", {31'h0, pslverr}, {31'h0, nt.err});
		end

	initial
	begin
		seed        = 32'hFADE;
		presetn     = 1'b0;
		req         = '0;
		ext_lvl     = 8'h00;
		acc_lvl     = 1'b0;
		frz_lvl     = 1'b0;
		n_mismatch  = 0;
		checks_done = 0;
		waitc(16);
		presetn <= 1'b1;
		@(posedge pclk);
		check("oe_n", {24'h0, port_oe_n}, 32'hFF);
		rd(tmc_pkg::OFS_CONFIG, 32'h0, 32'hFFFFFFFF);
		// compare channels 3..6 match the counter's first zero
		rd(tmc_pkg::OFS_FLAGS, 32'h78, 32'hFFFFFFFF);
		rd(8'h30, 32'h0, 32'hFFFFFFFF);
		apb(1'b1, tmc_pkg::OFS_ENABLES, 32'h7FF, 4'h1, 32'h0, 32'h0);
		rd(tmc_pkg::OFS_ENABLES, 32'hFF, 32'hFFFFFFFF);
		rnd = 8'($random(seed));
		wr(tmc_pkg::OFS_PORT_DIR, 32'hFF);
		wr(tmc_pkg::OFS_PORT_DATA, {24'h0, rnd});
		wr(tmc_pkg::OFS_PWM_DUTY, 32'h0);
		waitc(4);
		check("port out", {24'h0, port_out}, {24'h0, rnd});
		check("oe_n", {24'h0, port_oe_n}, 32'h0);
		check("pwm", {30'h0, pwm_out}, 32'h0);
		wr(tmc_pkg::OFS_PORT_DIR, 32'h0);
		ext_lvl <= rnd;
		waitc(6);
		rd(tmc_pkg::OFS_PORT_DATA, {24'h0, rnd}, 32'hFF);
		// pins latched while stepping is stopped
		wr(tmc_pkg::OFS_CONFIG, 32'h08);
		ext_lvl <= ~rnd;
		waitc(6);
		rd(tmc_pkg::OFS_PORT_DATA, {24'h0, rnd}, 32'hFF);
		wr(tmc_pkg::OFS_CONFIG, 32'h0);
		wr(tmc_pkg::OFS_ENABLES, 32'h400);
		wr(tmc_pkg::OFS_ACC_CTL, 32'h02);
		pulse();
		rd(tmc_pkg::OFS_FLAGS, 32'h400, 32'h400);
		check("irq", {31'h0, irq}, 32'h1);
		// a flag write disarms, so the zero write must not clear
		wr(tmc_pkg::OFS_FLAGS, 32'h7FF);
		wr(tmc_pkg::OFS_FLAGS, 32'h0);
		rd(tmc_pkg::OFS_FLAGS, 32'h400, 32'h400);
		check("irq", {31'h0, irq}, 32'h1);
		wr(tmc_pkg::OFS_FLAGS, 32'h0);
		waitc(3);
		check("irq", {31'h0, irq}, 32'h0);
		rd(tmc_pkg::OFS_FLAGS, 32'h0, 32'h400);
		pulse();
		wr(tmc_pkg::OFS_FLAGS, 32'h0);
		rd(tmc_pkg::OFS_FLAGS, 32'h400, 32'h400);
		// frozen: counter writable and held
		frz_lvl <= 1'b1;
		wr(tmc_pkg::OFS_CONFIG, 32'h0A);
		wr(tmc_pkg::OFS_COUNTER, 32'h1234);
		rd(tmc_pkg::OFS_COUNTER, 32'h1234, 32'hFFFF);
		waitc(10);
		rd(tmc_pkg::OFS_COUNTER, 32'h1234, 32'hFFFF);
		wr(tmc_pkg::OFS_PWM_CNT, 32'h0);
		wr(tmc_pkg::OFS_PWM_DUTY, 32'h0101);
		waitc(2);
		check("pwm", {30'h0, pwm_out}, 32'h3);
		wr(tmc_pkg::OFS_COUNTER, 32'h0);
		frz_lvl <= 1'b0;
		waitc(10);
		rd(tmc_pkg::OFS_COUNTER, 32'h0, 32'hFFFF);
		// four prescaler steps at divide by two give two ticks
		repeat (4) wr(tmc_pkg::OFS_CONFIG, 32'h1A);
		waitc(3);
		rd(tmc_pkg::OFS_COUNTER, 32'h2, 32'hFFFF);
		// spare bit alone must not freeze
		frz_lvl <= 1'b1;
		wr(tmc_pkg::OFS_CONFIG, 32'h04);
		wr(tmc_pkg::OFS_COUNTER, 32'h0);
		waitc(20);
		rd(tmc_pkg::OFS_COUNTER, 32'h8, 32'hFFF8);
		// low-power stop: only config and interrupt config touched
		// step bit with single step clear must do nothing
		wr(tmc_pkg::OFS_CONFIG, 32'h12);
		wr(tmc_pkg::OFS_COUNTER, 32'hAA);
		wr(tmc_pkg::OFS_CONFIG, 32'h03);
		frz_lvl <= 1'b0;
		waitc(20);
		rd(tmc_pkg::OFS_CONFIG, 32'h03, 32'h1F);
		wr(tmc_pkg::OFS_INT_CFG, 32'h5A);
		rd(tmc_pkg::OFS_INT_CFG, 32'h5A, 32'hFF);
		wr(tmc_pkg::OFS_CONFIG, 32'h0);
		rd(tmc_pkg::OFS_COUNTER, 32'hA8, 32'hFFF8);
		waitc(4);
		print_verdict();
	end
endmodule
`default_nettype wire
